// >>> src/clfi_exec.sv
// Purpose: Execute cache line flush and cache line invalidate instructions
// Assumes: Pipeline holds issue until issueReady; translation and cache answer by ack
// Notes:   One instruction in flight; events are one-cycle pulses from flops
`timescale 1ns/100ps
`include "clfi_map.svh"

module clfi_exec #(
  parameter int XLEN = 32
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // Issue from the pipeline
  input  wire logic              issueValid,
  output logic                   issueReady,
  input  wire logic [31:0]       instrWord,
  input  wire logic [XLEN-1:0]   baseRegValue,
  input  wire logic [XLEN-1:0]   indexRegValue,
  input  wire logic              dataRelocateBit,
  input  wire logic              instrRelocateBit,
  input  wire logic              supervisorState,
  // Address translation
  output logic                   xlReq,
  output logic [XLEN-1:0]        xlVirtAddr,
  output logic                   xlAsStore,
  input  wire logic              xlAck,
  input  wire logic              xlHasTranslation,
  input  wire logic              xlTlbMiss,
  input  wire logic              xlRealValid,
  input  wire logic [XLEN-1:0]   xlRealAddr,
  // Cache lookup and actions
  output logic                   cacheReq,
  output logic [XLEN-1:0]        cacheAddr,
  input  wire logic              cacheAck,
  input  wire logic              cacheIsIo,
  input  wire logic              dcPresent,
  input  wire logic              dcModified,
  input  wire logic              icPresent,
  output logic                   wbStart_r,
  output logic                   dcInval_r,
  output logic                   icInval_r,
  output logic                   refBitSet_r,
  // Retire
  output logic                   done_r,
  output logic                   baseRegWe_r,
  output logic [4:0]             baseRegIdx_r,
  output logic [XLEN-1:0]        baseRegData_r,
  output logic                   dataStorageInt_r,
  output logic                   dsisrFirstBitSet_r,
  output logic                   machineCheck_r,
  output logic                   privProgExc_r
);

  if (XLEN < 8) begin : g_bad_width
    $error("clfi_exec: XLEN below 8 is not served");
  end

  clfi_pkg::clfi_dec_t   dec;
  clfi_pkg::clfi_dec_t   cur_r;
  clfi_pkg::clfi_state_t state_r;
  logic [XLEN-1:0]       effectiveAddr_r;
  logic [XLEN-1:0]       effectiveAddrNxt;
  logic [XLEN-1:0]       realAddr_r;
  logic                  realBad_r;
  logic                  relocate_r;
  logic                  dsiFlag_r;
  logic                  privFlag_r;
  logic                  mchkFlag_r;
  logic                  accept;
  logic                  lookupDone;

  clfi_decode u_decode (
    .instrWord (instrWord),
    .dec       (dec)
  );

  // Other opcodes are never taken, so a wrong decode cannot disturb the caches
  assign issueReady = (state_r == clfi_pkg::ST_IDLE);
  assign accept     = issueValid && issueReady && (dec.isFlush || dec.isInval);
  assign effectiveAddrNxt = ((dec.baseRegField == `CLFI_ZERO_REG) ? '0 : baseRegValue)
                            + indexRegValue;
  assign lookupDone = (state_r == clfi_pkg::ST_LOOKUP) && cacheAck;

  // Handshake outputs are levels held while waiting
  assign xlReq      = (state_r == clfi_pkg::ST_XLATE);
  assign xlVirtAddr = effectiveAddr_r;
  assign xlAsStore  = cur_r.isInval;
  assign cacheReq   = (state_r == clfi_pkg::ST_LOOKUP);
  assign cacheAddr  = realAddr_r;

  // Sequencer; instruction relocate is deliberately unused once data relocate decides
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= clfi_pkg::ST_IDLE;
    end else begin
      case (state_r)
        clfi_pkg::ST_IDLE: begin
          if (accept) begin
            if (dec.isInval && !supervisorState) begin
              state_r <= clfi_pkg::ST_FINISH;
            end else if (dataRelocateBit) begin
              state_r <= clfi_pkg::ST_XLATE;
            end else begin
              state_r <= clfi_pkg::ST_LOOKUP;
            end
          end
        end
        clfi_pkg::ST_XLATE: begin
          if (xlAck) begin
            state_r <= xlHasTranslation ? clfi_pkg::ST_LOOKUP : clfi_pkg::ST_FINISH;
          end
        end
        clfi_pkg::ST_LOOKUP: begin
          if (cacheAck) begin
            state_r <= clfi_pkg::ST_FINISH;
          end
        end
        default: begin
          state_r <= clfi_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Captured instruction and address
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_r           <= '0;
      effectiveAddr_r <= '0;
      realAddr_r      <= '0;
      realBad_r       <= 1'b0;
      relocate_r      <= 1'b0;
    end else if (accept) begin
      cur_r           <= dec;
      effectiveAddr_r <= effectiveAddrNxt;
      realAddr_r      <= effectiveAddrNxt;
      realBad_r  <= 1'b0;
      relocate_r <= dataRelocateBit;
    end else if ((state_r == clfi_pkg::ST_XLATE) && xlAck) begin
      realAddr_r <= xlRealAddr;
      realBad_r  <= !xlRealValid;
    end
  end

  // Exception flags gathered over the instruction
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dsiFlag_r  <= 1'b0;
      privFlag_r <= 1'b0;
      mchkFlag_r <= 1'b0;
    end else if (accept) begin
      dsiFlag_r  <= 1'b0;
      privFlag_r <= dec.isInval && !supervisorState;
      mchkFlag_r <= 1'b0;
    end else if ((state_r == clfi_pkg::ST_XLATE) && xlAck) begin
      dsiFlag_r  <= !xlHasTranslation;
    end else if (lookupDone) begin
      mchkFlag_r <= cur_r.isFlush && realBad_r && !cacheIsIo && dcPresent;
    end
  end

  // Cache actions and reference bit, one-cycle pulses
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wbStart_r   <= `CLFI_PULSE_RST;
      dcInval_r   <= `CLFI_PULSE_RST;
      icInval_r   <= `CLFI_PULSE_RST;
      refBitSet_r <= `CLFI_PULSE_RST;
    end else begin
      refBitSet_r <= (state_r == clfi_pkg::ST_XLATE) && xlAck && xlTlbMiss;
      // A bad real address never reaches memory; I/O space is left alone
      if (lookupDone && !cacheIsIo && !realBad_r) begin
        wbStart_r <= cur_r.isFlush && dcPresent && dcModified;
        dcInval_r <= dcPresent;
        icInval_r <= icPresent;
      end else begin
        wbStart_r <= 1'b0;
        dcInval_r <= 1'b0;
        icInval_r <= 1'b0;
      end
    end
  end

  // Retire: base write-back and exceptions; fixed-point exception and condition
  // fields have no port, so the record bit is accepted and has no effect
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_r             <= `CLFI_PULSE_RST;
      baseRegWe_r        <= `CLFI_PULSE_RST;
      baseRegIdx_r       <= `CLFI_ZERO_REG;
      baseRegData_r      <= '0;
      dataStorageInt_r   <= `CLFI_PULSE_RST;
      dsisrFirstBitSet_r <= `CLFI_PULSE_RST;
      machineCheck_r     <= `CLFI_PULSE_RST;
      privProgExc_r      <= `CLFI_PULSE_RST;
    end else begin
      done_r             <= (state_r == clfi_pkg::ST_FINISH);
      baseRegWe_r        <= (state_r == clfi_pkg::ST_FINISH) && !dsiFlag_r && !privFlag_r
                            && (cur_r.baseRegField != `CLFI_ZERO_REG);
      baseRegIdx_r       <= cur_r.baseRegField;
      baseRegData_r      <= effectiveAddr_r;
      dataStorageInt_r   <= (state_r == clfi_pkg::ST_FINISH) && dsiFlag_r;
      dsisrFirstBitSet_r <= (state_r == clfi_pkg::ST_FINISH) && dsiFlag_r;
      machineCheck_r     <= (state_r == clfi_pkg::ST_FINISH) && mchkFlag_r;
      privProgExc_r      <= (state_r == clfi_pkg::ST_FINISH) && privFlag_r;
    end
  end

  // Checks
  addr_form_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    accept |=> effectiveAddr_r
               == (($past(dec.baseRegField) == `CLFI_ZERO_REG) ? '0 : $past(baseRegValue))
               + $past(indexRegValue))
    else $error("effective address wrong");
  decode_take_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (issueValid && issueReady && !dec.isFlush && !dec.isInval) |=> state_r == clfi_pkg::ST_IDLE)
    else $error("foreign opcode taken");
  real_mode_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    xlReq |-> relocate_r)
    else $error("translation asked in real mode");
  base_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    baseRegWe_r |-> baseRegData_r == effectiveAddr_r && baseRegIdx_r != `CLFI_ZERO_REG
    && !dataStorageInt_r)
    else $error("base write-back wrong");
  dsi_status_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (xlReq && xlAck && !xlHasTranslation) |-> ##2 (dataStorageInt_r && dsisrFirstBitSet_r
    && !baseRegWe_r))
    else $error("storage interrupt missing");
  flush_wb_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (lookupDone && cur_r.isFlush && !realBad_r && !cacheIsIo && dcPresent && dcModified)
    |=> wbStart_r && dcInval_r)
    else $error("modified line not written back");
  mchk_raise_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (lookupDone && cur_r.isFlush && realBad_r && !cacheIsIo && dcPresent) |-> ##2 machineCheck_r)
    else $error("machine check missing");
  ref_bit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (xlReq && xlAck && xlTlbMiss) |=> refBitSet_r)
    else $error("reference bit not set");
  io_noop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (lookupDone && cacheIsIo) |=> !wbStart_r && !dcInval_r && !icInval_r)
    else $error("cache action on I/O address");
  inval_both_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (lookupDone && cur_r.isInval && !realBad_r && !cacheIsIo) |=> dcInval_r == $past(dcPresent)
    && icInval_r == $past(icPresent) && !wbStart_r)
    else $error("invalidate missed a cache");
  priv_block_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (accept && dec.isInval && !supervisorState) |-> ##2 (privProgExc_r && !baseRegWe_r))
    else $error("privilege violation not trapped");

  flush_run_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    accept && dec.isFlush && dataRelocateBit ##[1:20] wbStart_r);
  inval_run_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    accept && dec.isInval ##[1:20] icInval_r);
  dsi_run_c: cover property (@(posedge ref_clk) disable iff (!rst_n) dataStorageInt_r);
  mchk_run_c: cover property (@(posedge ref_clk) disable iff (!rst_n) machineCheck_r);

endmodule

// >>> shared/clfi_map.svh
// Purpose: Opcode values, field positions and reset values for the cache line flush/invalidate unit
// Assumes: 32-bit instruction words, bit 0 of the printed layout is instr[31]
// Notes:   Definitions only
`ifndef CLFI_MAP_SVH
`define CLFI_MAP_SVH

`define CLFI_PRIMARY_OP  6'h1f
`define CLFI_XO_FLUSH    10'h076
`define CLFI_XO_INVAL    10'h1f6
`define CLFI_PO_LSB      26
`define CLFI_BASE_LSB    16
`define CLFI_INDEX_LSB   11
`define CLFI_XO_LSB      1
`define CLFI_RECORD_POS  0
`define CLFI_ZERO_REG    5'h00
`define CLFI_PULSE_RST   1'b0

`endif

// >>> shared/clfi_pkg.sv
// Purpose: Types shared by the cache line flush/invalidate unit
// Assumes: Register numbers are 5 bits
// Notes:   Constants live in clfi_map.svh
package clfi_pkg;

  typedef struct packed {
    logic       isFlush;
    logic       isInval;
    logic [4:0] baseRegField;
    logic [4:0] indexRegField;
    logic       recordBit;
  } clfi_dec_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_XLATE,
    ST_LOOKUP,
    ST_FINISH
  } clfi_state_t;

endpackage

// >>> src/clfi_decode.sv
// Purpose: Recognise the flush and invalidate instruction words and split their fields
// Assumes: Instruction word arrives decoded-ready from the pipeline
// Notes:   Purely combinational
`timescale 1ns/100ps
`include "clfi_map.svh"

module clfi_decode (
  // Instruction word
  input  wire logic [31:0]        instrWord,
  // Decoded fields
  output clfi_pkg::clfi_dec_t     dec
);

  logic [5:0] primaryOp;
  logic [9:0] extendedOp;

  assign primaryOp  = instrWord[`CLFI_PO_LSB +: 6];
  assign extendedOp = instrWord[`CLFI_XO_LSB +: 10];

  always_comb begin
    dec               = '0;
    dec.isFlush       = (primaryOp == `CLFI_PRIMARY_OP) && (extendedOp == `CLFI_XO_FLUSH);
    dec.isInval       = (primaryOp == `CLFI_PRIMARY_OP) && (extendedOp == `CLFI_XO_INVAL);
    dec.baseRegField  = instrWord[`CLFI_BASE_LSB +: 5];
    dec.indexRegField = instrWord[`CLFI_INDEX_LSB +: 5];
    dec.recordBit     = instrWord[`CLFI_RECORD_POS];
  end

endmodule

// >>> testbench/clfi_far_model.sv
// Purpose: Far-side model answering translation requests and cache lookups
// Assumes: One request at a time; the bench picks the delay and the outcome
// Notes:   Qualified fields toggle outside the acknowledge cycle so stale values never pass
`timescale 1ns/100ps
module clfi_far_model (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Bench controls: {hasTr, miss, realValid, isIo, dcP, dcM, icP}
  input  wire logic [1:0]  lag,
  input  wire logic [6:0]  cfg,
  input  wire logic [31:0] realOfs,
  // Translation
  input  wire logic        xlReq,
  input  wire logic [31:0] xlVirtAddr,
  output logic             xlAck,
  output logic             xlHasTranslation,
  output logic             xlTlbMiss,
  output logic             xlRealValid,
  output logic [31:0]      xlRealAddr,
  // Cache
  input  wire logic        cacheReq,
  output logic             cacheAck,
  output logic             cacheIsIo,
  output logic             dcPresent,
  output logic             dcModified,
  output logic             icPresent
);
  logic [1:0] waitCnt_r;
  logic       noise_r;
  logic       hit;

  assign hit = (xlReq | cacheReq) && (waitCnt_r == lag);
  // Cleared on the answer so the following request waits its full delay again
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) waitCnt_r <= 2'h0;
    else if ((xlReq | cacheReq) && !hit) waitCnt_r <= waitCnt_r + 2'h1;
    else waitCnt_r <= 2'h0;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) noise_r <= 1'b0;
    else noise_r <= ~noise_r;
  end
  assign xlAck            = xlReq && hit;
  assign cacheAck         = cacheReq && hit;
  assign xlHasTranslation = xlAck ? cfg[6] : noise_r;
  assign xlTlbMiss        = xlAck ? cfg[5] : noise_r;
  assign xlRealValid      = xlAck ? cfg[4] : noise_r;
  assign xlRealAddr       = xlAck ? (xlVirtAddr ^ realOfs) : {32{noise_r}};
  assign cacheIsIo        = cacheAck ? cfg[3] : noise_r;
  assign dcPresent        = cacheAck ? cfg[2] : noise_r;
  assign dcModified       = cacheAck ? cfg[1] : noise_r;
  assign icPresent        = cacheAck ? cfg[0] : noise_r;
endmodule

// >>> testbench/cache_line_flush_invalidate_tb.sv
// Purpose: Self-checking bench for the cache line flush/invalidate unit
// Assumes: Design idle between instructions; far side modelled by clfi_far_model
// Notes:   Corner cases first, then seeded random instructions
`timescale 1ns/100ps
module cache_line_flush_invalidate_tb;
  logic        ref_clk, rst_n, issueValid, issueReady, dataRelocateBit, instrRelocateBit;
  logic        supervisorState, xlReq, xlAsStore, xlAck, xlHasTranslation, xlTlbMiss;
  logic        xlRealValid, cacheReq, cacheAck, cacheIsIo, dcPresent, dcModified, icPresent;
  logic        wbStart_r, dcInval_r, icInval_r, refBitSet_r, done_r, baseRegWe_r;
  logic        dataStorageInt_r, dsisrFirstBitSet_r, machineCheck_r, privProgExc_r, gotStore;
  logic [31:0] instrWord, baseRegValue, indexRegValue, xlVirtAddr, xlRealAddr, cacheAddr;
  logic [31:0] baseRegData_r, realOfs, seed, gotVirt, gotCa;
  logic [31:0] nWb, nDc, nIc, nRef, nXl, nCa, nDone;
  logic [4:0]  baseRegIdx_r;
  logic [1:0]  lag;
  logic [6:0]  cfg, c;
  logic [31:0] r;
  int          errors, check_count, i;

  clfi_exec #(.XLEN(32)) u_dut (.ref_clk, .rst_n, .issueValid, .issueReady, .instrWord,
    .baseRegValue, .indexRegValue, .dataRelocateBit, .instrRelocateBit, .supervisorState,
    .xlReq, .xlVirtAddr, .xlAsStore, .xlAck, .xlHasTranslation, .xlTlbMiss, .xlRealValid,
    .xlRealAddr, .cacheReq, .cacheAddr, .cacheAck, .cacheIsIo, .dcPresent, .dcModified,
    .icPresent, .wbStart_r, .dcInval_r, .icInval_r, .refBitSet_r, .done_r, .baseRegWe_r,
    .baseRegIdx_r, .baseRegData_r, .dataStorageInt_r, .dsisrFirstBitSet_r, .machineCheck_r,
    .privProgExc_r);
  clfi_far_model u_far (.ref_clk, .rst_n, .lag, .cfg, .realOfs, .xlReq, .xlVirtAddr, .xlAck,
    .xlHasTranslation, .xlTlbMiss, .xlRealValid, .xlRealAddr, .cacheReq, .cacheAck,
    .cacheIsIo, .dcPresent, .dcModified, .icPresent);

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  function logic [31:0] next_rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function logic [31:0] exp_addr(logic [4:0] bf, logic [31:0] b, logic [31:0] x);
    return (bf == 5'h00 ? 32'h0 : b) + x;
  endfunction

  task check_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task check_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Pulses are counted per instruction; a doubled pulse shows up as a count of two
  always @(posedge ref_clk) begin
    if (rst_n) begin
      nWb = nWb + 32'(wbStart_r);
      nDc = nDc + 32'(dcInval_r);
      nIc = nIc + 32'(icInval_r);
      nRef = nRef + 32'(refBitSet_r);
      nDone = nDone + 32'(done_r);
      if (xlReq && xlAck) begin
        nXl++;
        gotVirt = xlVirtAddr;
        gotStore = xlAsStore;
      end
      if (cacheReq && cacheAck) begin
        nCa++;
        gotCa = cacheAddr;
      end
    end
  end

  task start(input logic [31:0] w);
    {nWb, nDc, nIc, nRef, nXl, nCa, nDone} = '0;
    instrWord = w;
    issueValid = 1'b1;
  endtask

  task run_one(input logic fl, input logic [4:0] bf, input logic [31:0] b, input logic [31:0] x,
               input logic reloc, input logic sup, input logic [6:0] cc);
    logic [31:0] addr, m;
    logic        priv, dsi, act;
    int          k;
    addr = exp_addr(bf, b, x);
    m = next_rnd();
    priv = !fl && !sup;
    dsi = !priv && reloc && !cc[6];
    act = !priv && !dsi && !cc[3] && (!reloc || cc[4]);
    @(posedge ref_clk) #1;
    baseRegValue = b;
    indexRegValue = x;
    dataRelocateBit = reloc;
    supervisorState = sup;
    instrRelocateBit = m[13];
    cfg = cc;
    lag = m[12:11];
    check_bit(issueReady, 1'b1);
    start({6'h1f, m[4:0], bf, m[9:5], fl ? 10'h076 : 10'h1f6, m[10]});
    @(posedge ref_clk) #1;
    issueValid = 1'b0;
    for (k = 0; k < 40 && done_r !== 1'b1; k++) @(posedge ref_clk) #1;
    check_bit(done_r, 1'b1);
    check_bit(baseRegWe_r, bf != 5'h00 && !dsi && !priv);
    if (bf != 5'h00 && !dsi && !priv) begin
      check_word({27'h0, baseRegIdx_r}, {27'h0, bf});
      check_word(baseRegData_r, addr);
    end
    check_bit(dataStorageInt_r, dsi);
    check_bit(dsisrFirstBitSet_r, dsi);
    check_bit(machineCheck_r, fl && reloc && !dsi && !cc[4] && !cc[3] && cc[2]);
    check_bit(privProgExc_r, priv);
    check_word(nXl, 32'(!priv && reloc));
    check_word(nCa, 32'(!priv && !dsi));
    if (nXl == 32'h1) check_word(gotVirt, addr);
    if (nXl == 32'h1) check_bit(gotStore, !fl);
    check_word(nRef, 32'(!priv && reloc && cc[5]));
    if (nCa == 32'h1) check_word(gotCa, reloc ? addr ^ realOfs : addr);
    check_word(nWb, 32'(act && fl && cc[2] && cc[1]));
    check_word(nDc, 32'(act && cc[2]));
    check_word(nIc, 32'(act && cc[0]));
  endtask

  task final_report;
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    #60000;
    errors++;
    final_report;
  end

  initial begin
    {rst_n, issueValid, dataRelocateBit, instrRelocateBit, supervisorState} = '0;
    {instrWord, baseRegValue, indexRegValue, realOfs} = '0;
    {lag, cfg, errors, check_count} = '0;
    seed = 32'hd633;
    repeat (3) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    realOfs = 32'h0f00_0000;
    run_one(1'b1, 5'h00, 32'hffff_ffff, 32'h20, 1'b0, 1'b0, 7'h07);
    run_one(1'b0, 5'h04, 32'h0033_0020, 32'h20, 1'b0, 1'b0, 7'h07);
    run_one(1'b0, 5'h05, 32'h1000, 32'h4, 1'b1, 1'b1, 7'h07);
    run_one(1'b1, 5'h1f, 32'h1000, 32'h8, 1'b1, 1'b1, 7'h44);
    run_one(1'b0, 5'h03, 32'h2000, 32'h10, 1'b1, 1'b1, 7'h7f);
    run_one(1'b0, 5'h00, 32'h2000, 32'h10, 1'b0, 1'b1, 7'h05);
    // Wrong extended opcode, then wrong primary opcode: never taken
    for (i = 0; i < 2; i++) begin
      @(posedge ref_clk) #1;
      start(i == 0 ? {6'h1f, 15'h0421, 10'h075, 1'b0} : {6'h1e, 15'h0421, 10'h076, 1'b0});
      repeat (8) @(posedge ref_clk) #1;
      issueValid = 1'b0;
      check_word(nDone + nXl + nCa, 32'h0);
    end
    for (i = 0; i < 150; i++) begin
      r = next_rnd();
      c = 7'(next_rnd());
      c[5] = c[5] & c[6];
      c[4] = c[4] | !r[0];
      realOfs = next_rnd();
      run_one(r[0], r[5:1], next_rnd(), next_rnd(), r[6], r[7] | r[8], c);
    end
    final_report;
  end
endmodule
